/* File: dv/rcp_pin_model.sv */
`timescale 1ns/1ps

// External reset circuit on an open-drain pin with a pull-up; either side may pull it low.
module rcp_pin_model (
    input  wire logic pull_low,
    input  wire logic dev_out,
    input  wire logic dev_oe,
    output logic      pin_n
);
    // Released by both sides the pull-up wins, so the line reads high.
    assign pin_n = (dev_oe ? dev_out : 1'b1) & ~pull_low;
endmodule // rcp_pin_model

/* File: dv/rcp_reset_power_checker.sv */
`timescale 1ns/1ps

// Watches the reset sequencer from its ports; all checks live in the core clock domain.
module rcp_reset_power_checker (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        rst_pin_oe,
    input wire logic        supply_low,
    input wire logic        watchdog_overflow,
    input wire logic        code_addr_error,
    input wire logic        wake_irq,
    input wire logic        core_reset,
    input wire logic        sfr_reset,
    input wire logic        ram_write_block,
    input wire logic        internal_osc_sel,
    input wire logic        interrupts_off,
    input wire logic        timers_off,
    input wire logic        port_force_open_drain,
    input wire logic [7:0]  port_latch_value,
    input wire logic        weak_pullup_en,
    input wire logic        boot_fetch,
    input wire logic [15:0] pc_load_value,
    input wire logic        cpu_clock_en,
    input wire logic        osc_halt,
    input wire logic        idle_mode,
    input wire logic        stop_mode,
    input wire logic        watchdog_en,
    input wire logic        watchdog_tick,
    input wire logic        supply_monitor_en
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Mode bits must never be visible to software, whatever was written.
    mode_bits_a: assert property (sfr_rd && sfr_addr == 8'h87 |=> sfr_rdata[1:0] == 2'b00)
        else $error("mode bits read back nonzero");
    reset_entry_a: assert property (core_reset |-> interrupts_off && timers_off
        && port_force_open_drain) else $error("reset does not quiet the chip");
    pullup_on_a: assert property (weak_pullup_en) else $error("weak pullups off");
    ram_guard_a: assert property (core_reset |-> sfr_reset && ram_write_block)
        else $error("registers or memory not guarded in reset");
    osc_default_a: assert property ($fell(core_reset) |-> internal_osc_sel)
        else $error("oscillator not internal after reset");
    // Exit must launch the boot fetch with clean ports and a running watchdog.
    reset_exit_a: assert property ($fell(core_reset) |-> boot_fetch && pc_load_value == 16'h0000
        && port_latch_value == 8'hFF && watchdog_en) else $error("bad reset exit");
    wdt_period_a: assert property (watchdog_tick ##1 (watchdog_en && !core_reset)[*8]
        ##1 (watchdog_en && !core_reset)[*3] |=> watchdog_tick)
        else $error("watchdog tick period wrong");
    wdt_reset_a: assert property (watchdog_overflow && !core_reset |-> ##[1:3] core_reset)
        else $error("watchdog overflow did not reset");
    pin_quiet_a: assert property ((watchdog_overflow || code_addr_error) && !core_reset
        && !supply_monitor_en |=> (!rst_pin_oe)[*8]) else $error("internal reset drove pin");
    supply_hold_a: assert property (supply_monitor_en && supply_low && !core_reset
        |-> ##[1:6] (core_reset && rst_pin_oe)) else $error("low supply not held");
    monitor_on_a: assert property (sfr_wr && sfr_addr == 8'hEF && sfr_wdata[1] && !core_reset
        |=> supply_monitor_en) else $error("monitor not enabled");
    monitor_keep_a: assert property (supply_monitor_en |=> supply_monitor_en)
        else $error("monitor enable lost");
    soft_reset_a: assert property (sfr_wr && sfr_addr == 8'hEF && sfr_wdata == 8'h10
        && !core_reset |=> core_reset[*4] ##1 !core_reset) else $error("soft reset length");
    idle_enter_a: assert property (sfr_wr && sfr_addr == 8'h87 && sfr_wdata[0] && !core_reset
        |=> idle_mode && !cpu_clock_en) else $error("idle not entered");
    idle_wake_a: assert property (idle_mode && wake_irq && !core_reset
        && !(sfr_wr && sfr_addr == 8'h87 && sfr_wdata[0]) |=> !idle_mode)
        else $error("interrupt did not end idle");
    stop_enter_a: assert property (sfr_wr && sfr_addr == 8'h87 && sfr_wdata[1] && !core_reset
        |=> stop_mode && osc_halt) else $error("stop not entered");
    stop_stay_a: assert property (stop_mode && !core_reset |=> stop_mode || core_reset)
        else $error("stop left without reset");
endmodule // rcp_reset_power_checker

bind rcp_reset_power rcp_reset_power_checker i_rcp_reset_power_checker (.*);

/* File: dv/rcp_reset_power_tb_top.sv */
`timescale 1ns/1ps

module rcp_reset_power_tb_top;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic       sfr_wr = 1'b0, sfr_rd = 1'b0, supply_low = 1'b0, comparator_below = 1'b0;
    logic       clock_loss_timeout = 1'b0, watchdog_overflow = 1'b0, code_addr_error = 1'b0;
    logic       wake_irq = 1'b0, pin_pull = 1'b0, wd_off = 1'b0, osc_ext = 1'b0;
    logic       wd_en, osc_int;
    logic       rst_pin_n_in, rst_pin_out, rst_pin_oe;
    logic       core_reset, idle_mode, stop_mode, cpu_clock_en, supply_monitor_en;
    logic [7:0] exp_tab [6] = '{8'h08, 8'h40, 8'h04, 8'h20, 8'h01, 8'h10};
    int         n_errors = 0, tests_run = 0;

    // A short power-up delay keeps the run brief; checks derive from this value.
    always #2.5 clock = ~clock;

    rcp_reset_power #(.POR_DELAY_CYCLES(20)) i_rcp_reset_power (
        .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .rst_pin_n_in(rst_pin_n_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .supply_low(supply_low), .comparator_below(comparator_below),
        .clock_loss_timeout(clock_loss_timeout), .watchdog_overflow(watchdog_overflow),
        .code_addr_error(code_addr_error), .wake_irq(wake_irq), .watchdog_disable(wd_off),
        .clock_switch_ext(osc_ext), .core_reset(core_reset), .sfr_reset(), .interrupts_off(),
        .timers_off(), .ram_write_block(), .port_force_open_drain(), .port_latch_value(),
        .weak_pullup_en(), .boot_fetch(), .pc_load_value(), .cpu_clock_en(cpu_clock_en),
        .osc_halt(), .idle_mode(idle_mode), .stop_mode(stop_mode), .watchdog_en(wd_en),
        .watchdog_tick(), .internal_osc_sel(osc_int), .supply_monitor_en(supply_monitor_en));

    rcp_pin_model i_rcp_pin_model (.pull_low(pin_pull), .dev_out(rst_pin_out),
        .dev_oe(rst_pin_oe), .pin_n(rst_pin_n_in));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Writes are taken on the edge after the strobe rises, so it drops on that edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clock);
        sfr_rd <= 1'b0;
        #1 chk(sfr_rdata, exp);
    endtask

    // Polls on the falling edge so the registered reset level is settled.
    task automatic wait_for(input logic v);
        int i;
        i = 0;
        while (core_reset !== v && i < 100) begin
            @(negedge clock);
            i++;
        end
        chk({7'h00, core_reset}, {7'h00, v});
    endtask

    // Raises one reset source, drops every source once reset is seen, then reads the cause.
    task automatic cause(input int s, input logic [7:0] exp);
        @(posedge clock);
        case (s)
            0: watchdog_overflow <= 1'b1;
            1: code_addr_error <= 1'b1;
            2: begin wr(8'hEF, 8'h04); clock_loss_timeout <= 1'b1; end
            3: begin wr(8'hEF, 8'h20); comparator_below <= 1'b1; end
            4: pin_pull <= 1'b1;
            5: wr(8'hEF, 8'h10);
            default: supply_low <= 1'b1;
        endcase
        wait_for(1'b1);
        @(posedge clock);
        {watchdog_overflow, code_addr_error, clock_loss_timeout} <= 3'b000;
        {comparator_below, pin_pull, supply_low} <= 3'b000;
        wait_for(1'b0);
        rd(8'hEF, exp);
    endtask

    task automatic summarize;
        $display("Errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence: power-up, register access, idle, every reset source, then stop.
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (15) @(negedge clock);
        chk({7'h00, core_reset}, 8'h01);
        wait_for(1'b0);
        rd(8'hEF, 8'h02);
        rd(8'h87, 8'h00);
        rd(8'h80, 8'h00);
        chk({7'h00, supply_monitor_en}, 8'h00);
        chk({7'h00, rst_pin_oe}, 8'h00);
        wr(8'h87, 8'hFD);
        #1 chk({cpu_clock_en, idle_mode}, 8'h01);
        rd(8'h87, 8'hFC);
        @(posedge clock);
        wake_irq <= 1'b1;
        repeat (2) @(posedge clock);
        wake_irq <= 1'b0;
        #1 chk({7'h00, idle_mode}, 8'h00);
        for (int s = 0; s < 6; s++) cause(s, exp_tab[s]);
        rd(8'h87, 8'h00);
        wr(8'hEF, 8'h04);
        wr(8'hEF, 8'h00);
        clock_loss_timeout <= 1'b1;
        repeat (8) @(negedge clock);
        chk({7'h00, core_reset}, 8'h00);
        @(posedge clock);
        clock_loss_timeout <= 1'b0;
        wr(8'hEF, 8'h02);
        #1 chk({7'h00, supply_monitor_en}, 8'h01);
        cause(5, 8'h10);
        chk({7'h00, supply_monitor_en}, 8'h01);
        // Software turns the watchdog off and picks the external clock; a reset undoes both.
        @(posedge clock);
        {wd_off, osc_ext} <= 2'b11;
        @(posedge clock);
        {wd_off, osc_ext} <= 2'b00;
        #1 chk({6'h00, wd_en, osc_int}, 8'h00);
        cause(6, 8'h02);
        chk({6'h00, wd_en, osc_int}, 8'h03);
        wr(8'h87, 8'h02);
        repeat (10) @(negedge clock);
        chk({7'h00, stop_mode}, 8'h01);
        cause(0, 8'h08);
        chk({7'h00, stop_mode}, 8'h00);
        summarize();
    end

    // The full sequence needs well under two thousand cycles; this cuts a hang short.
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        summarize();
    end
endmodule // rcp_reset_power_tb_top

/* File: rtl/rcp_pkg.sv */
package rcp_pkg;

    // Register addresses on the special function register port.
    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] RESET_CAUSE_ADDR   = 8'hEF;
    localparam logic [7:0] POWER_CONTROL_RST  = 8'h00;

    // Field positions in the power control register.
    localparam int GFLAG_MSB = 7;
    localparam int GFLAG_LSB = 2;
    localparam int STOP_BIT  = 1;
    localparam int IDLE_BIT  = 0;

    // Field positions in the reset cause register; bit 7 reads zero.
    localparam int PIN_BIT  = 0;
    localparam int POR_BIT  = 1;
    localparam int CLK_BIT  = 2;
    localparam int WDT_BIT  = 3;
    localparam int SOFT_BIT = 4;
    localparam int CMP_BIT  = 5;
    localparam int MEM_BIT  = 6;
    localparam int CAUSE_W  = 7;

    // Timing, from the 200 MHz core clock.
    localparam int CLOCK_PERIOD_PS = 5000;
    localparam int POR_DELAY_NS    = 300000;
    localparam int POR_DELAY_CYC   = POR_DELAY_NS * 1000 / CLOCK_PERIOD_PS;
    localparam int WDT_DIVIDE      = 12;
    localparam int RESET_HOLD_CYC  = 4;
    localparam int PIN_GUARD_CYC   = 6;

    // Values applied to the rest of the chip around reset.
    localparam logic [7:0]  PORT_RESET_VALUE = 8'hFF;
    localparam logic [15:0] RESET_VECTOR     = 16'h0000;

    typedef enum logic [1:0] {
        RCP_RUN    = 2'b00,
        RCP_HOLD   = 2'b01,
        RCP_POWER  = 2'b10,
        RCP_SUPPLY = 2'b11
    } rcp_state_t;

endpackage

/* File: rtl/rcp_reset_power.sv */
`timescale 1ns/1ps

// Operation
// - Power control bits 7:2 are software flags.
// - Power control bit 1 enters stop; reads 0.
// - Power control bit 0 gates CPU clock; reads 0.
// - Reset halts core, resets registers, ports, interrupts.
// - Reset keeps data memory; stack pointer reinitialised.
// - Ports all ones open drain; pullups stay on.
// - Power and supply resets drive pin low.
// - Exit clears PC, internal oscillator, watchdog on.
// - Power-up adds release delay before leaving reset.
// - Power or supply reset sets power flag only.
// - Only power-on reset clears supply monitor enable.
// - Low supply holds reset; release without delay.
// - Writing power flag enables supply monitor reset.
// - Pin driven low resets; sets pin flag.
// - Clock-loss timeout resets and sets its flag.
// - Clock-loss flag write enables or disables detector.
// - Bit 5 arms comparator reset, flags it.
// - Watchdog on at core_clock/12; overflow resets.
// - Code address over limit resets, sets flag.
// - Writing bit 4 forces reset; reads 1 after.
// - Internal resets leave the reset pin alone.
// - Enabled interrupt clears idle and resumes CPU.
// - Stop ends only by reset, fetch at zero.
// - Watchdog cause flag sits at bit 3.
module rcp_reset_power import rcp_pkg::*; #(
    parameter int unsigned POR_DELAY_CYCLES = POR_DELAY_CYC,
    parameter int          CNT_W            = 16
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        rst_pin_n_in,
    output logic             rst_pin_out,
    output logic             rst_pin_oe,
    input  wire logic        supply_low,
    input  wire logic        comparator_below,
    input  wire logic        clock_loss_timeout,
    input  wire logic        watchdog_overflow,
    input  wire logic        code_addr_error,
    input  wire logic        wake_irq,
    input  wire logic        watchdog_disable,
    input  wire logic        clock_switch_ext,
    output logic             core_reset,
    output logic             sfr_reset,
    output logic             interrupts_off,
    output logic             timers_off,
    output logic             ram_write_block,
    output logic             port_force_open_drain,
    output logic [7:0]       port_latch_value,
    output logic             weak_pullup_en,
    output logic             boot_fetch,
    output logic [15:0]      pc_load_value,
    output logic             cpu_clock_en,
    output logic             osc_halt,
    output logic             idle_mode,
    output logic             stop_mode,
    output logic             watchdog_en,
    output logic             watchdog_tick,
    output logic             internal_osc_sel,
    output logic             supply_monitor_en
);

    localparam logic [CNT_W-1:0] POR_LAST  = CNT_W'(POR_DELAY_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(RESET_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] GUARD_CYC = CNT_W'(PIN_GUARD_CYC);
    localparam logic [3:0]       WDT_LAST  = 4'(WDT_DIVIDE - 1);

    typedef struct packed {
        rcp_state_t           st;
        logic [CNT_W-1:0]     cnt;
        logic [CNT_W-1:0]     guard;
        logic [CAUSE_W-1:0]   pend;
        logic [CAUSE_W-1:0]   flags;
        logic                 mon_en;
        logic                 clk_en;
        logic                 cmp_en;
        logic [5:0]           gflags;
        logic                 idle;
        logic                 stop;
        logic [7:0]           rdata;
        logic                 boot;
        logic                 wdt_en;
        logic [3:0]           wdiv;
        logic                 wtick;
        logic                 int_osc;
        logic                 pin_oe;
        logic [7:0]           port_val;
        logic [15:0]          pc_val;
    } rcp_state_s_t;

    rcp_state_s_t s;
    rcp_state_s_t next_s;

    logic [2:0] raw_in;
    logic [2:0] sync_in;
    logic       pin_low;
    logic       sup_low;
    logic       cmp_low;
    logic       clk_lost;

    // Single-bit one-hot cause vector for a given flag position.
    function automatic logic [CAUSE_W-1:0] cause_bit(input int pos);
        cause_bit = CAUSE_W'(1) << pos;
    endfunction

    // Pin and analog levels come from outside the clock domain.
    assign raw_in = {rst_pin_n_in, supply_low, comparator_below};

    rcp_sync3 #(
        .WIDTH     (3),
        .RESET_VAL (3'h4)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (raw_in),
        .sync_out (sync_in)
    );

    // The one-shot timeout is itself asynchronous to a clock it says is missing.
    rcp_sync3 #(
        .WIDTH     (1),
        .RESET_VAL (1'h0)
    ) u_sync_clk (
        .clock    (clock),
        .rst      (rst),
        .async_in (clock_loss_timeout),
        .sync_out (clk_lost)
    );

    // While this block drives the pin low, or just after, the pin echo is ignored.
    assign pin_low = ~sync_in[2] & ~s.pin_oe & (s.guard == '0);
    assign sup_low = sync_in[1];
    assign cmp_low = sync_in[0];

    always_comb begin
        logic              wr_power_control;
        logic              wr_cause;
        logic [CAUSE_W-1:0] hit;
        logic              leave;
        wr_power_control  = 1'b0;
        wr_cause = 1'b0;
        hit      = '0;
        leave    = 1'b0;
        next_s       = s;
        next_s.boot  = 1'b0;
        next_s.wtick = 1'b0;
        if (s.guard != '0) begin
            next_s.guard = s.guard - CNT_W'(1);
        end

        // Register writes are only taken while the core runs.
        if (s.st == RCP_RUN && sfr_wr) begin
            wr_power_control  = (sfr_addr == POWER_CONTROL_ADDR);
            wr_cause = (sfr_addr == RESET_CAUSE_ADDR);
        end

        // A wake clears idle first, so a new idle request in the same cycle still wins.
        if (s.idle && wake_irq) begin
            next_s.idle = 1'b0;
        end

        // Power control: flags store, mode bits trigger and read back zero.
        if (wr_power_control) begin
            next_s.gflags = sfr_wdata[GFLAG_MSB:GFLAG_LSB];
            if (sfr_wdata[STOP_BIT]) begin
                next_s.stop = 1'b1;
            end
            if (sfr_wdata[IDLE_BIT]) begin
                next_s.idle = 1'b1;
            end
        end

        // Reset cause writes: enables for monitor, detector and comparator.
        if (wr_cause) begin
            if (sfr_wdata[POR_BIT]) begin
                next_s.mon_en = 1'b1;
            end
            next_s.clk_en = sfr_wdata[CLK_BIT];
            if (sfr_wdata[CMP_BIT]) begin
                next_s.cmp_en = 1'b1;
            end
        end

        // Collect every source except the supply monitor that asks for a reset in this cycle.
        hit[PIN_BIT]  = pin_low;
        hit[CLK_BIT]  = s.clk_en & clk_lost;
        hit[CMP_BIT]  = s.cmp_en & cmp_low;
        hit[WDT_BIT]  = s.wdt_en & watchdog_overflow;
        hit[MEM_BIT]  = code_addr_error;
        hit[SOFT_BIT] = wr_cause & sfr_wdata[SOFT_BIT];

        // Read data is registered; mode bits and reset cause bit 7 read as zero.
        if (sfr_rd) begin
            if (sfr_addr == POWER_CONTROL_ADDR) begin
                next_s.rdata = {s.gflags, 2'b00};
            end else if (sfr_addr == RESET_CAUSE_ADDR) begin
                next_s.rdata = {1'b0, s.flags};
            end else begin
                next_s.rdata = 8'h00;
            end
        end

        // Reset sequencer.
        case (s.st)
            RCP_RUN: begin
                if (s.mon_en && sup_low) begin
                    next_s.st     = RCP_SUPPLY;
                    next_s.pend   = cause_bit(POR_BIT);
                    next_s.pin_oe = 1'b1;
                end else if (hit != '0) begin
                    next_s.st   = RCP_HOLD;
                    next_s.cnt  = '0;
                    // The pin has priority; otherwise the lowest flag wins.
                    next_s.pend = hit[PIN_BIT] ? cause_bit(PIN_BIT) : (hit & (~hit + CAUSE_W'(1)));
                end
            end
            RCP_POWER: begin
                next_s.cnt = s.cnt + CNT_W'(1);
                if (s.cnt == POR_LAST) begin
                    leave = 1'b1;
                end
            end
            RCP_SUPPLY: begin
                if (!sup_low) begin
                    leave = 1'b1;
                end
            end
            RCP_HOLD: begin
                if (s.mon_en && sup_low) begin
                    next_s.st     = RCP_SUPPLY;
                    next_s.pend   = cause_bit(POR_BIT);
                    next_s.pin_oe = 1'b1;
                end else begin
                    if (s.cnt != HOLD_LAST) begin
                        next_s.cnt = s.cnt + CNT_W'(1);
                    end
                    // A pin reset lasts as long as the other party holds the pin low.
                    if (s.cnt == HOLD_LAST && !(s.pend[PIN_BIT] && pin_low)) begin
                        leave = 1'b1;
                    end
                end
            end
            default: begin
                next_s.st = RCP_POWER;
            end
        endcase

        // Every reset clears registers to reset values; the monitor enable survives.
        if (s.st == RCP_RUN && next_s.st != RCP_RUN) begin
            next_s.gflags   = '0;
            next_s.idle     = 1'b0;
            next_s.stop     = 1'b0;
            next_s.clk_en   = 1'b0;
            next_s.cmp_en   = 1'b0;
            next_s.wdt_en   = 1'b0;
            next_s.port_val = PORT_RESET_VALUE;
        end

        // Leaving reset: record the cause and restart the core from the vector.
        if (leave) begin
            next_s.st      = RCP_RUN;
            next_s.flags   = s.pend;
            next_s.pin_oe  = 1'b0;
            next_s.guard   = GUARD_CYC;
            next_s.boot    = 1'b1;
            next_s.pc_val  = RESET_VECTOR;
            next_s.int_osc = 1'b1;
            next_s.wdt_en  = 1'b1;
            next_s.wdiv    = '0;
        end

        // Watchdog runs from a core_clock/12 enable while the core is out of reset.
        if (s.st == RCP_RUN && !leave) begin
            if (s.wdiv == WDT_LAST) begin
                next_s.wdiv  = '0;
                next_s.wtick = s.wdt_en;
            end else begin
                next_s.wdiv = s.wdiv + 4'h1;
            end
            if (watchdog_disable) begin
                next_s.wdt_en = 1'b0;
            end
            if (clock_switch_ext) begin
                next_s.int_osc = 1'b0;
            end
        end
    end

    // The asynchronous reset is the power-on reset: it is the only thing that
    // clears the supply monitor enable, and it starts the release delay.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s          <= '0;
            s.st       <= RCP_POWER;
            s.pend     <= cause_bit(POR_BIT);
            s.flags    <= '0;
            s.mon_en   <= 1'b0;
            s.pin_oe   <= 1'b1;
            s.port_val <= PORT_RESET_VALUE;
            s.int_osc  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Internal resets never enable the pin driver; only power and supply do.
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe  = s.pin_oe;

    // Reset-time controls to the core and peripherals.
    assign core_reset            = (s.st != RCP_RUN);
    assign sfr_reset             = core_reset;
    assign interrupts_off        = core_reset;
    assign timers_off            = core_reset | s.stop;
    assign ram_write_block       = core_reset;
    assign port_force_open_drain = core_reset;
    assign port_latch_value      = s.port_val;
    assign weak_pullup_en        = 1'b1;
    assign boot_fetch            = s.boot;
    assign pc_load_value         = s.pc_val;

    // Idle stops only the CPU clock; stop also halts the oscillator.
    assign cpu_clock_en      = ~(core_reset | s.idle | s.stop);
    assign osc_halt          = s.stop;
    assign idle_mode         = s.idle;
    assign stop_mode         = s.stop;
    assign watchdog_en       = s.wdt_en;
    assign watchdog_tick     = s.wtick;
    assign internal_osc_sel  = s.int_osc;
    assign supply_monitor_en = s.mon_en;
    assign sfr_rdata         = s.rdata;

endmodule // rcp_reset_power

/* File: rtl/rcp_sync3.sv */
`timescale 1ns/1ps

// Three-stage synchroniser; a new level is accepted once stages two and three agree.
module rcp_sync3 import rcp_pkg::*; #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] ff1;
        logic [WIDTH-1:0] ff2;
        logic [WIDTH-1:0] ff3;
        logic [WIDTH-1:0] q;
    } rcp_sync_t;

    rcp_sync_t s;
    rcp_sync_t next_s;

    // Stage one feeds stage two only; the filter looks at stages two and three.
    always_comb begin
        next_s     = s;
        next_s.ff1 = async_in;
        next_s.ff2 = s.ff1;
        next_s.ff3 = s.ff2;
        next_s.q   = (~(s.ff2 ^ s.ff3) & s.ff2) | ((s.ff2 ^ s.ff3) & s.q);
    end

    // All stages start at the idle level of the input.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.q;

endmodule // rcp_sync3
